// file: rtl/icc_core.sv
/*
 One enhanced input capture channel: control registers on classic
 Wishbone, edge modes, channel counter, 4-entry capture buffer.
 Assumes timer ticks, source strobes and cascade inputs are same-clock
 pulses; capture pin and sleep/idle levels are asynchronous.
*/
// Function
// R1: 3-bit time base select; 111 system clock, 100..000 timers, 110/101 reserved.
// R2: Read-only overflow flag sets when capture arrives with buffer full.
// R3: Mode 111 gives a rising-edge wake interrupt only in sleep or idle.
// R4: Mode 110 disables the channel; no captures.
// R5: Mode 101 captures on every sixteenth rising edge.
// R6: Cascade bit set in both pair channels forms one 32-bit unit.
// R7: Cascade bit clear runs an independent 16-bit channel.
// R8: Trigger bit 1 waits for trigger; 0 resyncs counter to source.
// R9: Trigger status sets by hardware on trigger; software may set it.
// R10: Trigger status zero holds the counter cleared and stopped.
// R11: Sync code 00000 selects no source.
// R12: Codes 01011..01111 select timers 1..5.
// R13: Codes 00001..01001 select compare channels 1..9.
// R14: Listed codes select capture channels 1..9.
// R15: Software uses analog codes 11000..11100 only as triggers.
// R16: Codes 11111 and 1000x are reserved, no source.
// R17: Unimplemented control bits read zero, ignore writes.
// R18: Free-running counter wraps; each capture pushes counter value.
// R19: Buffer-not-empty stays set until every entry is read.
// R20: Source 00000 with trigger set waits for software trigger status.
// R21: Cascade odd channel is low half; its wrap increments the even.
// R22: Interrupt rate 1..4 captures per interrupt; ignored in both-edge mode.
// R23: Modes 100 every 4th rise, 011 rise, 010 fall, 001 both, 000 off.
// R24: Halt-in-idle bit stops the channel while chip is idle.
`timescale 1ns/100ps
module icc_core
	import icc_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire icc_wb_req_s wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic capture_input_i,
	input wire logic idle_i,
	input wire logic sleep_i,
	input wire logic [4:0] timer_tick_i,
	input wire icc_src_s src_i,
	input wire logic cascade_carry_i,
	output logic cascade_carry_o,
	output logic capture_irq_o,
	output logic capture_event_o
);
	typedef struct packed {
		logic [15:0] ctrl1;
		logic [15:0] ctrl2;
		logic [15:0] cnt;
		logic [3:0][15:0] buf_mem;
		logic [1:0] rd_ptr;
		logic [1:0] wr_ptr;
		logic [2:0] fill;
		logic [3:0] presc;
		logic [1:0] irq_cnt;
		logic [2:0] pin_sync;
		logic [3:0] pm_sync;
		logic [31:0] rdat;
		logic ack;
		logic carry;
		logic irq;
		logic evt;
	} icc_state_s;

	icc_state_s s_q;
	icc_state_s s_d;
	logic src_hit;
	logic src_valid;

	////////////////////////////////////////////////////////////////
	// Source selector
	icc_src_sel u_src_sel (
		.code_i(s_q.ctrl2[ICC_P_SYNC +: 5]),
		.src_i(src_i),
		.hit_o(src_hit),
		.valid_o(src_valid)
	);

	////////////////////////////////////////////////////////////////
	// Next-state logic
	logic [2:0] mode;
	logic [2:0] tsel;
	logic pin;
	logic rise;
	logic fall;
	logic tick;
	logic run;
	logic cap;
	logic casc;
	logic trig;
	logic wr;
	logic rd;
	logic [15:0] wval;

	always_comb
	begin
		s_d = s_q;
		mode = s_q.ctrl1[ICC_P_MODE +: 3];
		tsel = s_q.ctrl1[ICC_P_TSEL +: 3];
		casc = s_q.ctrl2[ICC_P_CASC];
		trig = s_q.ctrl2[ICC_P_TRIG];
		// Stage 2 of each synchroniser feeds logic; pin stage 3 also feeds the edge detect
		pin = s_q.pin_sync[1];
		rise = pin & ~s_q.pin_sync[2];
		fall = ~pin & s_q.pin_sync[2];
		s_d.pin_sync = {pin, s_q.pin_sync[0], capture_input_i};
		s_d.pm_sync = {s_q.pm_sync[2], sleep_i, s_q.pm_sync[0], idle_i};
		s_d.ack = 1'b0;
		s_d.irq = 1'b0;
		s_d.evt = 1'b0;
		s_d.carry = 1'b0;
		wr = wb_i.cyc & wb_i.stb & wb_i.we & ~s_q.ack & wb_i.sel[0] & wb_i.sel[1];
		rd = wb_i.cyc & wb_i.stb & ~wb_i.we & ~s_q.ack;
		wval = wb_i.dat[15:0];
		// R1: time base tick select, reserved codes never tick
		case (tsel)
			ICC_TB_SYS: tick = 1'b1;
			ICC_TB_T1: tick = timer_tick_i[0];
			ICC_TB_T2: tick = timer_tick_i[1];
			ICC_TB_T3: tick = timer_tick_i[2];
			ICC_TB_T4: tick = timer_tick_i[3];
			ICC_TB_T5: tick = timer_tick_i[4];
			default: tick = 1'b0;
		endcase
		// R6: cascaded upper half counts on the partner carry
		if (casc)
			tick = cascade_carry_i;
		// R24: halt in idle; R4: disabled modes stop
		run = !(s_q.ctrl1[ICC_P_HALT] && s_q.pm_sync[1])
			&& mode != ICC_M_OFF && mode != ICC_M_DIS && mode != ICC_M_WAKE;
		// R9: hardware sets trigger status on trigger event
		if (trig && src_valid && src_hit)
			s_d.ctrl2[ICC_P_TSTAT] = 1'b1;
		// R20: free-running and sync modes need no trigger
		if (!trig)
			s_d.ctrl2[ICC_P_TSTAT] = 1'b1;
		// R10: held clear until triggered
		if (trig && !s_q.ctrl2[ICC_P_TSTAT])
			s_d.cnt = 16'h0000;
		// R8: sync mode resets counter on source event
		else if (!trig && src_valid && src_hit)
			s_d.cnt = 16'h0000;
		// R18: free running count with wrap; R21: carry out on wrap
		else if (run && tick)
		begin
			s_d.cnt = s_q.cnt + 16'h0001;
			s_d.carry = (s_q.cnt == 16'hFFFF);
		end
		// R23: edge decode; R5: sixteenth rise via prescaler
		cap = 1'b0;
		unique case (mode)
			ICC_M_BOTH: cap = rise | fall;
			ICC_M_FALL: cap = fall;
			ICC_M_RISE: cap = rise;
			ICC_M_DIV4, ICC_M_DIV16:
			begin
				if (rise)
				begin
					s_d.presc = s_q.presc + 4'h1;
					cap = (mode == ICC_M_DIV4) ? (s_q.presc[1:0] == 2'h3)
						: (s_q.presc == ICC_PRESCALE_LAST);
				end
			end
			// R3: wake interrupt only in sleep or idle
			ICC_M_WAKE: s_d.irq = rise & (s_q.pm_sync[1] | s_q.pm_sync[3]);
			ICC_M_OFF, ICC_M_DIS: s_d.presc = 4'h0;
		endcase
		// R7: cascaded channel keeps its own buffer of its half
		cap = cap & run & (!trig || s_q.ctrl2[ICC_P_TSTAT]);
		// Read of the buffer pops one entry
		s_d.rdat = 32'h0000_0000;
		if (rd)
		begin
			unique case (wb_i.adr)
				ICC_OFS_CTRL1: s_d.rdat = {16'h0000, s_q.ctrl1};
				ICC_OFS_CTRL2: s_d.rdat = {16'h0000, s_q.ctrl2};
				ICC_OFS_BUF:
				begin
					s_d.rdat = {16'h0000, s_q.buf_mem[s_q.rd_ptr]};
					// R19: pop clears not-empty after last entry
					if (s_q.fill != 3'h0)
					begin
						s_d.rd_ptr = s_q.rd_ptr + 2'h1;
						s_d.fill = s_q.fill - 3'h1;
					end
				end
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end
		if (cap)
		begin
			s_d.evt = 1'b1;
			// R2: full buffer sets overflow and drops the value
			if (s_d.fill == 3'(ICC_DEPTH))
				s_d.ctrl1[ICC_P_OVF] = 1'b1;
			else
			begin
				// R18: push current counter value
				s_d.buf_mem[s_q.wr_ptr] = s_q.cnt;
				s_d.wr_ptr = s_q.wr_ptr + 2'h1;
				s_d.fill = s_d.fill + 3'h1;
			end
			// R22: interrupt every 1..4 captures; every edge in both mode
			if (mode == ICC_M_BOTH || s_q.irq_cnt == s_q.ctrl1[ICC_P_IRATE +: 2])
			begin
				s_d.irq = 1'b1;
				s_d.irq_cnt = 2'h0;
			end
			else
				s_d.irq_cnt = s_q.irq_cnt + 2'h1;
		end
		// R2: hardware clears overflow once the buffer drains
		if (s_d.fill == 3'h0 && !cap)
			s_d.ctrl1[ICC_P_OVF] = 1'b0;
		// R19: not-empty tracks the fill level
		s_d.ctrl1[ICC_P_BNE] = (s_d.fill != 3'h0);
		// R17: writes reach only implemented bits
		if (wr && wb_i.adr == ICC_OFS_CTRL1)
		begin
			s_d.ctrl1 = (s_d.ctrl1 & ~ICC_MASK1) | (wval & ICC_MASK1);
			s_d.irq_cnt = 2'h0;
		end
		if (wr && wb_i.adr == ICC_OFS_CTRL2)
		begin
			// R9: software may set status; hardware set wins a clear
			s_d.ctrl2 = (wval & ICC_MASK2)
				| {9'h000, s_d.ctrl2[ICC_P_TSTAT] & ~s_q.ctrl2[ICC_P_TSTAT], 6'h00};
		end
		if (wb_i.cyc && wb_i.stb && !s_q.ack)
			s_d.ack = 1'b1;
		if (!rd)
			s_d.rdat = s_q.rdat & {32{1'b0}};
		else if (wb_i.adr == ICC_OFS_STAT)
			s_d.rdat = {26'h0, s_q.fill, s_q.irq_cnt, s_q.ctrl2[ICC_P_TSTAT]};
	end

	////////////////////////////////////////////////////////////////
	// State register, frozen while clock enable is low
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s_q <= '0;
		else if (clk_en_i)
			s_q <= s_d;
	end

	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	assign cascade_carry_o = s_q.carry;
	assign capture_irq_o = s_q.irq;
	assign capture_event_o = s_q.evt;

	////////////////////////////////////////////////////////////////
	// Checks
	overflow_on_full_a: // R2
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		clk_en_i && cap && s_q.fill == 3'h4 && !rd
		|=> s_q.ctrl1[ICC_P_OVF])
	else $error("overflow flag not set on full buffer");

	bne_tracks_fill_a: // R19
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_q.ctrl1[ICC_P_BNE] == (s_q.fill != 3'h0))
	else $error("not-empty flag disagrees with fill");

	disabled_no_cap_a: // R4
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		clk_en_i && s_q.ctrl1[2:0] == ICC_M_DIS |=> !s_q.evt)
	else $error("capture while disabled");

	held_clear_a: // R10
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		clk_en_i && trig && !s_q.ctrl2[ICC_P_TSTAT] && !(wr && wb_i.adr == ICC_OFS_CTRL2)
		|=> s_q.cnt == 16'h0000)
	else $error("counter ran before trigger");

	wrap_carry_a: // R21
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_q.carry |-> s_q.cnt == 16'h0000)
	else $error("carry without wrap");

	reserved_bits_a: // R17
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(s_q.ctrl1 & ~(ICC_MASK1 | 16'h0018)) == 16'h0 && (s_q.ctrl2 & ~ICC_MASK2) == 16'h0)
	else $error("reserved control bits set");

	ack_one_cycle_a: // Wishbone ack lasts one cycle
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_q.ack && clk_en_i |=> !s_q.ack)
	else $error("ack held two cycles");

	sync_reset_a: // R8
	assert property (@(posedge clk_i) disable iff (!reset_n_i)
		clk_en_i && !trig && src_valid && src_hit |=> s_q.cnt == 16'h0000)
	else $error("sync event did not reset counter");
endmodule : icc_core

// file: rtl/icc_pkg.sv
/*
 Package for the input capture control block: register offsets, field
 positions, reset values, mode and source codes, and the packed carriers.
 Assumes a 32-bit classic Wishbone register bus and one 50 MHz clock.
*/
package icc_pkg;
	// Register word offsets (byte addresses)
	localparam logic [3:0] ICC_OFS_CTRL1 = 4'h0;
	localparam logic [3:0] ICC_OFS_CTRL2 = 4'h4;
	localparam logic [3:0] ICC_OFS_BUF = 4'h8;
	localparam logic [3:0] ICC_OFS_STAT = 4'hC;
	// Primary control field positions
	localparam int ICC_P_HALT = 13;
	localparam int ICC_P_TSEL = 10;
	localparam int ICC_P_IRATE = 5;
	localparam int ICC_P_OVF = 4;
	localparam int ICC_P_BNE = 3;
	localparam int ICC_P_MODE = 0;
	// Secondary control field positions
	localparam int ICC_P_CASC = 8;
	localparam int ICC_P_TRIG = 7;
	localparam int ICC_P_TSTAT = 6;
	localparam int ICC_P_SYNC = 0;
	// Writable bit masks; other bits read zero, except the read-only OVF and BNE flags
	localparam logic [15:0] ICC_MASK1 = 16'h3C67;
	localparam logic [15:0] ICC_MASK2 = 16'h01DF;
	localparam logic [15:0] ICC_RESET_VAL = 16'h0000;
	// Buffer depth
	localparam int ICC_DEPTH = 4;
	localparam logic [3:0] ICC_PRESCALE_LAST = 4'hF;
	// Capture mode codes
	localparam logic [2:0] ICC_M_OFF = 3'h0;
	localparam logic [2:0] ICC_M_BOTH = 3'h1;
	localparam logic [2:0] ICC_M_FALL = 3'h2;
	localparam logic [2:0] ICC_M_RISE = 3'h3;
	localparam logic [2:0] ICC_M_DIV4 = 3'h4;
	localparam logic [2:0] ICC_M_DIV16 = 3'h5;
	localparam logic [2:0] ICC_M_DIS = 3'h6;
	localparam logic [2:0] ICC_M_WAKE = 3'h7;
	// Time base codes
	localparam logic [2:0] ICC_TB_T3 = 3'h0;
	localparam logic [2:0] ICC_TB_T2 = 3'h1;
	localparam logic [2:0] ICC_TB_T4 = 3'h2;
	localparam logic [2:0] ICC_TB_T5 = 3'h3;
	localparam logic [2:0] ICC_TB_T1 = 3'h4;
	localparam logic [2:0] ICC_TB_SYS = 3'h7;
	// Sync source codes
	localparam logic [4:0] ICC_S_NONE = 5'h00;
	localparam logic [4:0] ICC_S_OC1 = 5'h01;
	localparam logic [4:0] ICC_S_OC9 = 5'h09;
	localparam logic [4:0] ICC_S_IC5 = 5'h0A;
	localparam logic [4:0] ICC_S_TM1 = 5'h0B;
	localparam logic [4:0] ICC_S_TM5 = 5'h0F;
	localparam logic [4:0] ICC_S_IC7 = 5'h12;
	localparam logic [4:0] ICC_S_IC8 = 5'h13;
	localparam logic [4:0] ICC_S_IC1 = 5'h14;
	localparam logic [4:0] ICC_S_IC4 = 5'h17;
	localparam logic [4:0] ICC_S_AN0 = 5'h18;
	localparam logic [4:0] ICC_S_AN4 = 5'h1C;
	localparam logic [4:0] ICC_S_IC6 = 5'h1D;
	localparam logic [4:0] ICC_S_IC9 = 5'h1E;

	// Event sources offered to the selector
	typedef struct packed {
		logic [4:0] timer;
		logic [8:0] compare;
		logic [8:0] capture;
		logic [4:0] analog;
	} icc_src_s;

	// Wishbone request
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [3:0] adr;
		logic [31:0] dat;
	} icc_wb_req_s;
endpackage : icc_pkg

// file: rtl/icc_src_sel.sv
/*
 Sync and trigger source selector: decodes the 5-bit source code into one
 event strobe. Assumes the source strobes are same-clock pulses.
*/
`timescale 1ns/100ps
module icc_src_sel
	import icc_pkg::*;
(
	input wire logic [4:0] code_i,
	input wire icc_src_s src_i,
	output logic hit_o,
	output logic valid_o
);
	////////////////////////////////////////////////////////////////
	// Code to source decode
	always_comb
	begin
		hit_o = 1'b0;
		valid_o = 1'b1;
		// R11: no source at all
		if (code_i == ICC_S_NONE)
			valid_o = 1'b0;
		// R13: compare channels 1..9
		else if (code_i >= ICC_S_OC1 && code_i <= ICC_S_OC9)
			hit_o = src_i.compare[4'(code_i - ICC_S_OC1)];
		// R14: capture channel 5
		else if (code_i == ICC_S_IC5)
			hit_o = src_i.capture[4];
		// R12: timers 1..5 ascending
		else if (code_i >= ICC_S_TM1 && code_i <= ICC_S_TM5)
			hit_o = src_i.timer[3'(code_i - ICC_S_TM1)];
		// R14: capture channels 7, 8
		else if (code_i == ICC_S_IC7 || code_i == ICC_S_IC8)
			hit_o = src_i.capture[4'(code_i - ICC_S_IC7) + 4'h6];
		// R14: capture channels 1..4
		else if (code_i >= ICC_S_IC1 && code_i <= ICC_S_IC4)
			hit_o = src_i.capture[4'(code_i - ICC_S_IC1)];
		// R15: trigger-only analog sources
		else if (code_i >= ICC_S_AN0 && code_i <= ICC_S_AN4)
			hit_o = src_i.analog[3'(code_i - ICC_S_AN0)];
		// R14: capture channels 6 and 9
		else if (code_i == ICC_S_IC6)
			hit_o = src_i.capture[5];
		else if (code_i == ICC_S_IC9)
			hit_o = src_i.capture[8];
		// R16: reserved codes select nothing
		else
			valid_o = 1'b0;
	end
endmodule : icc_src_sel

// file: testbench/icc_pin_model.sv
/*
 Model of the pulse source on the capture input pin.
 Assumes it shares the bench clock; the pin idles low between pulses.
*/
`timescale 1ns/100ps
module icc_pin_model
(
	input wire logic clk_i,
	output logic pin_o
);
	initial pin_o = 1'b0;

	////////////////////////////////////////////////////////////////
	// Square pulses, high and low for half cycles each
	task automatic pulses(input int n, input int half);
		repeat (n)
		begin
			@(posedge clk_i);
			pin_o <= 1'b1;
			repeat (half) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (half - 1) @(posedge clk_i);
		end
	endtask : pulses
endmodule : icc_pin_model

// file: testbench/tb_top.sv
/*
 Bench for the capture channel: registers, edge modes, buffer, overflow,
 sources, trigger and cascade. Assumes one 50 MHz clock.
*/
`timescale 1ns/100ps
module tb_top
	import icc_pkg::*;
;
	typedef struct {
		logic [15:0] c1;
		logic idle;
		int n;
		int ev;
		int irq;
	} icc_row_s;

	logic clk = 1'b0;
	// Reset from time zero so no check ever sees unknown state
	logic reset_n = 1'b0;
	icc_wb_req_s wb_q = '0;
	logic [31:0] wb_dat;
	logic wb_ack;
	logic pin;
	logic idle = 1'b0;
	icc_src_s src_q = '0;
	logic carry_q = 1'b0;
	logic [4:0] tick_q = 5'h00;
	logic carry_o;
	logic irq;
	logic ev;
	int n_errors = 0;
	int tests_run = 0;
	int ev_n = 0;
	int irq_n = 0;
	int carry_n = 0;
	int cyc_n = 0;
	logic [31:0] rd;
	logic [15:0] b [4];
	// Pin activity per mode; overflowed captures still count as events
	icc_row_s rows [9] = '{
		'{16'h1C00, 1'b0, 16, 0, 0},
		'{16'h1C61, 1'b0, 2, 4, 4},
		'{16'h1C02, 1'b0, 4, 4, 4},
		'{16'h1C04, 1'b0, 16, 4, 4},
		'{16'h1C05, 1'b0, 16, 1, 1},
		'{16'h1C06, 1'b0, 16, 0, 0},
		'{16'h1C07, 1'b0, 16, 0, 0},
		'{16'h1C07, 1'b1, 16, 0, 16},
		'{16'h3C03, 1'b1, 16, 0, 0}};

	always #10 clk = ~clk;

	icc_pin_model u_pin (.clk_i(clk), .pin_o(pin));

	icc_core u_dut (.clk_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1), .wb_i(wb_q),
		.wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .capture_input_i(pin), .idle_i(idle),
		.sleep_i(1'b0), .timer_tick_i(tick_q), .src_i(src_q), .cascade_carry_i(carry_q),
		.cascade_carry_o(carry_o), .capture_irq_o(irq), .capture_event_o(ev));

	////////////////////////////////////////////////////////////////
	// Output pulse counters and the hang limit
	always @(posedge clk)
	begin
		ev_n += ev;
		irq_n += irq;
		carry_n += carry_o;
		cyc_n++;
		// Full 16-bit wrap test dominates the run time
		if (cyc_n == 80000)
		begin
			n_errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Classic cycle; held until ack is sampled, then released
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		@(posedge clk);
		wb_q <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
		do
			@(posedge clk);
		while (wb_ack !== 1'b1);
		rd = wb_dat;
		wb_q.cyc <= 1'b0;
		wb_q.stb <= 1'b0;
	endtask : wb

	task automatic rst();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		ev_n = 0;
		irq_n = 0;
	endtask : rst

	// Arms trigger mode on a code, fires one source strobe, reads status
	task automatic trig(input logic [4:0] code, input icc_src_s s, input logic [31:0] exp);
		wb(1'b1, ICC_OFS_CTRL2, {24'h0, 3'h4, code});
		src_q <= s;
		@(posedge clk);
		src_q <= '0;
		wb(1'b0, ICC_OFS_CTRL2, 32'h0);
		chk(rd, exp);
	endtask : trig

	task automatic settle();
		repeat (12) @(posedge clk);
	endtask : settle

	// Three strobes on tick, carry or source lines, then one capture read back
	task automatic cnt_test(input logic [15:0] c2, input logic [15:0] c1,
		input logic [4:0] tk, input logic cy, input icc_src_s s, input logic [15:0] exp);
		rst();
		wb(1'b1, ICC_OFS_CTRL2, {16'h0, c2});
		wb(1'b1, ICC_OFS_CTRL1, {16'h0, c1});
		repeat (3)
		begin
			@(posedge clk);
			tick_q <= tk;
			carry_q <= cy;
			src_q <= s;
			@(posedge clk);
			tick_q <= 5'h00;
			carry_q <= 1'b0;
			src_q <= '0;
		end
		u_pin.pulses(1, 5);
		settle();
		wb(1'b0, ICC_OFS_BUF, 32'h0);
		chk(rd, {16'h0, exp});
	endtask : cnt_test

	task automatic end_sim();
		$display("tests %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////
	initial
	begin
		rst();
		wb(1'b0, ICC_OFS_CTRL1, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, ICC_OFS_CTRL1, 32'hFFFF_FFFF);
		wb(1'b0, ICC_OFS_CTRL1, 32'h0);
		chk(rd, 32'h3C67);
		wb(1'b1, ICC_OFS_CTRL2, 32'hFFFF_FFFF);
		wb(1'b0, ICC_OFS_CTRL2, 32'h0);
		chk(rd, 32'h01DF);
		wb(1'b1, 4'h2, 32'hFFFF_FFFF);
		wb(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		$display("registers done");
		foreach (rows[i])
		begin
			rst();
			idle <= rows[i].idle;
			wb(1'b1, ICC_OFS_CTRL1, {16'h0, rows[i].c1});
			u_pin.pulses(rows[i].n, 5);
			settle();
			chk(ev_n, rows[i].ev);
			chk(irq_n, rows[i].irq);
		end
		$display("modes done");
		// fifth capture overflows a full buffer
		rst();
		idle <= 1'b0;
		wb(1'b1, ICC_OFS_CTRL1, 32'h3C63);
		u_pin.pulses(5, 5);
		settle();
		chk(irq_n, 1);
		wb(1'b0, ICC_OFS_CTRL1, 32'h0);
		chk(rd, 32'h3C7B);
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b0, ICC_OFS_BUF, 32'h0);
			b[i] = rd[15:0];
		end
		for (int i = 1; i < 4; i++)
			chk(16'(b[i] - b[i - 1]), 16'd10);
		wb(1'b0, ICC_OFS_CTRL1, 32'h0);
		chk(rd, 32'h3C63);
		$display("overflow done");
		// only the selected source fires the trigger
		trig(5'h1F, '1, 32'h9F);
		trig(5'h10, '1, 32'h90);
		trig(5'h00, '1, 32'h80);
		trig(5'h0B, 28'h1000000, 32'h8B);
		trig(5'h0B, 28'h0800000, 32'hCB);
		trig(5'h0F, 28'h8000000, 32'hCF);
		trig(5'h09, 28'h0400000, 32'hC9);
		trig(5'h14, 28'h0000020, 32'hD4);
		trig(5'h1E, 28'h0002000, 32'hDE);
		trig(5'h18, 28'h0000001, 32'hD8);
		$display("sources done");
		// counter held clear until software trigger
		rst();
		wb(1'b1, ICC_OFS_CTRL2, 32'h80);
		wb(1'b1, ICC_OFS_CTRL1, 32'h1C03);
		u_pin.pulses(1, 5);
		settle();
		wb(1'b0, ICC_OFS_CTRL1, 32'h0);
		chk(rd, 32'h1C03);
		wb(1'b1, ICC_OFS_CTRL2, 32'hC0);
		u_pin.pulses(1, 5);
		settle();
		wb(1'b0, ICC_OFS_BUF, 32'h0);
		b[0] = rd[15:0];
		wb(1'b0, ICC_OFS_BUF, 32'h0);
		chk(16'(b[0] | rd[15:0]) !== 16'h0, 1'b1);
		$display("trigger done");
		// cascade counts only partner wraps; time base codes; sync reset
		cnt_test(16'h0100, 16'h1C03, 5'h00, 1'b1, '0, 16'h0003);
		cnt_test(16'h0000, 16'h1003, 5'h01, 1'b0, '0, 16'h0003);
		cnt_test(16'h0000, 16'h1003, 5'h02, 1'b0, '0, 16'h0000);
		cnt_test(16'h0000, 16'h0803, 5'h08, 1'b0, '0, 16'h0003);
		cnt_test(16'h0000, 16'h1803, 5'h1F, 1'b0, '0, 16'h0000);
		cnt_test(16'h000B, 16'h1C03, 5'h00, 1'b0, 28'h0800000, 16'h0003);
		$display("cascade done");
		// a full count wraps once and carries out once
		rst();
		wb(1'b1, ICC_OFS_CTRL1, 32'h1C03);
		carry_n = 0;
		repeat (65540) @(posedge clk);
		chk(carry_n, 1);
		$display("wrap done");
		end_sim();
	end
endmodule : tb_top
